// ### verilog/sbtc_pkg.sv
// sbtc_pkg: constants shared by the sixteen-bit timer/counter block.
// assumes a 32-bit classic wishbone register bus, one register per aligned word.
package sbtc_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_COUNT_LOW  = 8'h00;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h04;
  localparam logic [7:0] ADDR_FLAG       = 8'h08;
  localparam logic [7:0] ADDR_ENABLE     = 8'h0C;
  localparam logic [7:0] ADDR_CONTROL    = 8'h10;

  // control register field positions
  localparam int CTL_RUN      = 0;
  localparam int CTL_CS       = 1;
  localparam int CTL_SYNC_DIS = 2;
  localparam int CTL_OSC_EN   = 3;
  localparam int CTL_PS_LO    = 4;
  localparam int CTL_PS_HI    = 5;
  localparam int CTL_W        = 6;

  // flag / enable register field position
  localparam int OVF_BIT = 0;

  // values after reset
  localparam logic [5:0] CTL_RESET = 6'h00;
  localparam logic       FLAG_RESET = 1'b0;
  localparam logic       ENA_RESET  = 1'b0;

  // cycle counts
  localparam int          INSTR_CYCLES = 4;  // oscillator cycles per instruction cycle
  localparam logic [1:0]  INSTR_LAST   = 2'h3;
  localparam int          COUNT_W      = 16;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
  localparam int          PSC_W        = 3;

  // prescale select encodings
  typedef enum logic [1:0] {
    SBTC_PS_1 = 2'h0,
    SBTC_PS_2 = 2'h1,
    SBTC_PS_4 = 2'h2,
    SBTC_PS_8 = 2'h3
  } sbtc_ps_t;

endpackage : sbtc_pkg

// ### verilog/sbtc_pin_sync.sv
// sbtc_pin_sync: two-flop synchroniser for one pin, with rising-edge pulse.
// assumes the pin is asynchronous to clk_i; the first flop feeds only the second.
`timescale 1ns/1ps
module sbtc_pin_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // pin side
  input  wire logic pin_i,
  // synchronised side
  output logic      level_o,
  output logic      rise_o
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // two-stage synchroniser, then one extra stage for edge finding
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // edge detector reads only the second and third stages
  assign level_o = sync_ff;
  assign rise_o  = sync_ff & ~last_ff;

endmodule : sbtc_pin_sync

// ### verilog/sbtc_timer.sv
// sbtc_timer: sixteen-bit timer/counter with prescaler, overflow interrupt and
// wishbone register access.
// assumes clk_i is the oscillator clock, ccp_reset_i is a one-cycle pulse on
// clk_i, and the oscillator pins are resolved by the surrounding pad logic.
`timescale 1ns/1ps

// Overview of operation
// - count kept as high and low bytes, both readable and writable by software.
// - count runs upward from zero to all ones, then wraps to zero.
// - wrap sets latched overflow flag bit 0; interrupt only while enable bit 0 set.
// - control bit 1 picks timer operation when clear, counter operation when set.
// - timer operation advances once per instruction cycle, a quarter of oscillator rate.
// - counter operation advances on each rising edge of the external clock.
// - control bit 0 lets the count advance when set, freezes it when clear.
// - capture/compare unit has a reset input that clears the count.
// - with oscillator enabled both oscillator pins are inputs, ignoring direction bits.
// - control bit 3 turns the oscillator on; clear turns its amplifier off.
// - control bit 2 selects whether the external clock is phase synchronised.
// - control register at 0x10, bits 7:6 unimplemented, 5:0 read/write, reset zero.
// - with the internal clock selected, the synchronisation bit has no effect.
// - any software write to a count byte also clears the prescaler.
// - software count write beats a simultaneous capture/compare reset pulse.
// - resets leave count bytes unchanged; only capture/compare reset clears them.
module sbtc_timer #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // capture/compare unit
  input  wire logic              ccp_reset_i,
  output logic      [15:0]       count_o,
  // port bits shared with the oscillator pins: [1] osc_in_pin, [0] osc_out_pin
  input  wire logic [1:0]        port_direction_bits_i,
  input  wire logic [1:0]        port_out_i,
  // oscillator input pin (counter source while the oscillator is on)
  input  wire logic              osc_in_pin_i,
  output logic                   osc_in_pin_o,
  output logic                   osc_in_pin_oe_o,
  // oscillator output pin, doubling as the external clock pin
  input  wire logic              osc_out_pin_i,
  output logic                   osc_out_pin_o,
  output logic                   osc_out_pin_oe_o,
  // oscillator amplifier and interrupt
  output logic                   osc_amp_en_o,
  output logic                   irq_o
);

  // refuse address widths too narrow for the register map
  if (ADDR_W < 5) begin : g_bad_addr_w
    $error("sbtc_timer: ADDR_W must be at least 5");
  end

  // control fields
  logic [sbtc_pkg::CTL_W-1:0]   ctl_ff;
  logic                         counter_run;
  logic                         clock_source_select;
  logic                         ext_sync_disable;
  logic                         low_power_osc_enable;
  logic [1:0]                   prescale_select;

  // count, prescaler and timing state
  logic [sbtc_pkg::COUNT_W-1:0] count_ff;
  logic [sbtc_pkg::PSC_W-1:0]   psc_ff;
  logic [sbtc_pkg::PSC_W-1:0]   psc_mask;
  logic [1:0]                   phase_ff;
  logic                         pend_ff;
  logic                         overflow_flag_ff;
  logic                         overflow_irq_enable_ff;

  // bus state
  logic                         ack_ff;
  logic [31:0]                  dat_ff;
  logic [7:0]                   adr;
  logic                         req;
  logic                         wr_go;
  logic                         wr_low;
  logic                         wr_high;
  logic                         wr_count;
  logic                         wr_flag;
  logic                         wr_ena;
  logic                         wr_ctl;
  logic [31:0]                  nxt_dat;

  // event terms
  logic                         osc_in_rise;
  logic                         ext_pin_rise;
  logic                         ext_rise;
  logic                         instr_tick;
  logic                         phase_q;
  logic                         src_ev;
  logic                         pre_tick;
  logic                         sync_path;
  logic                         inc;
  logic                         ovf_ev;
  logic                         nxt_flag;

  assign counter_run          = ctl_ff[sbtc_pkg::CTL_RUN];
  assign clock_source_select  = ctl_ff[sbtc_pkg::CTL_CS];
  assign ext_sync_disable     = ctl_ff[sbtc_pkg::CTL_SYNC_DIS];
  assign low_power_osc_enable = ctl_ff[sbtc_pkg::CTL_OSC_EN];
  assign prescale_select      = ctl_ff[sbtc_pkg::CTL_PS_HI:sbtc_pkg::CTL_PS_LO];

  // pin synchronisers; both run always so a source switch sees settled levels
  sbtc_pin_sync u_sync_osc_in (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (osc_in_pin_i),
    .level_o (),
    .rise_o  (osc_in_rise)
  );

  sbtc_pin_sync u_sync_ext_clk (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (osc_out_pin_i),
    .level_o (),
    .rise_o  (ext_pin_rise)
  );

  assign osc_in_pin_oe_o  = ~low_power_osc_enable & ~port_direction_bits_i[1];
  assign osc_out_pin_oe_o = ~low_power_osc_enable & ~port_direction_bits_i[0];
  assign osc_in_pin_o     = port_out_i[1];
  assign osc_out_pin_o    = port_out_i[0];

  // oscillator amplifier enable; off means no bias current drawn
  assign osc_amp_en_o = low_power_osc_enable;

  // bus decode; the low address byte selects the register, upper bits must be zero
  assign adr      = 8'(wb_adr_i);
  assign req      = wb_cyc_i & wb_stb_i;
  assign wr_go    = req & ack_ff & wb_we_i & wb_sel_i[0] & (wb_adr_i >> 8 == '0);
  assign wr_low   = wr_go & (adr == sbtc_pkg::ADDR_COUNT_LOW);
  assign wr_high  = wr_go & (adr == sbtc_pkg::ADDR_COUNT_HIGH);
  assign wr_flag  = wr_go & (adr == sbtc_pkg::ADDR_FLAG);
  assign wr_ena   = wr_go & (adr == sbtc_pkg::ADDR_ENABLE);
  assign wr_ctl   = wr_go & (adr == sbtc_pkg::ADDR_CONTROL);
  assign wr_count = wr_low | wr_high;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // read mux; unmapped addresses read as zero and are still acknowledged
  always_comb begin
    nxt_dat = 32'h0000_0000;
    if (wb_adr_i >> 8 == '0) begin
      case (adr)
        sbtc_pkg::ADDR_COUNT_LOW: begin
          nxt_dat[7:0] = count_ff[7:0];
        end
        sbtc_pkg::ADDR_COUNT_HIGH: begin
          nxt_dat[7:0] = count_ff[15:8];
        end
        sbtc_pkg::ADDR_FLAG: begin
          nxt_dat[sbtc_pkg::OVF_BIT] = overflow_flag_ff;
        end
        sbtc_pkg::ADDR_ENABLE: begin
          nxt_dat[sbtc_pkg::OVF_BIT] = overflow_irq_enable_ff;
        end
        sbtc_pkg::ADDR_CONTROL: begin
          nxt_dat[sbtc_pkg::CTL_W-1:0] = ctl_ff;
        end
        default: begin
          nxt_dat = 32'h0000_0000;
        end
      endcase
    end
  end

  // read data captured on the edge that raises ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= 32'h0000_0000;
    end else if (req & ~ack_ff & ~wb_we_i) begin
      dat_ff <= nxt_dat;
    end
  end

  assign wb_dat_o = dat_ff;
  assign wb_ack_o = ack_ff;

  // control register, six writable bits, cleared by reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_ff <= sbtc_pkg::CTL_RESET;
    end else if (wr_ctl) begin
      ctl_ff <= wb_dat_i[sbtc_pkg::CTL_W-1:0];
    end
  end

  // interrupt enable register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_irq_enable_ff <= sbtc_pkg::ENA_RESET;
    end else if (wr_ena) begin
      overflow_irq_enable_ff <= wb_dat_i[sbtc_pkg::OVF_BIT];
    end
  end

  // instruction phase counter, free running on the oscillator clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_ff <= 2'h0;
    end else begin
      phase_ff <= phase_ff + 2'h1;
    end
  end

  assign instr_tick = (phase_ff == sbtc_pkg::INSTR_LAST);
  // sampling points standing in for the second and fourth internal phases
  assign phase_q    = phase_ff[0];

  // external source: oscillator input while it runs, else the clock pin
  assign ext_rise = low_power_osc_enable ? osc_in_rise : ext_pin_rise;

  // source select; run gate stops events before the prescaler
  assign src_ev = counter_run & (clock_source_select ? ext_rise : instr_tick);

  // prescale ratio as a mask on the prescaler count
  always_comb begin
    case (sbtc_pkg::sbtc_ps_t'(prescale_select))
      sbtc_pkg::SBTC_PS_1: psc_mask = 3'h0;
      sbtc_pkg::SBTC_PS_2: psc_mask = 3'h1;
      sbtc_pkg::SBTC_PS_4: psc_mask = 3'h3;
      sbtc_pkg::SBTC_PS_8: psc_mask = 3'h7;
      default:             psc_mask = 3'h0;
    endcase
  end

  // prescaler; output pulse when all masked bits are ones
  assign pre_tick = src_ev & ((psc_ff & psc_mask) == psc_mask);

  always_ff @(posedge clk_i) begin
    if (rst_i | wr_count) begin
      psc_ff <= 3'h0;
    end else if (src_ev) begin
      psc_ff <= psc_ff + 3'h1;
    end
  end

  // synchronised counter mode waits for the next phase sample point
  // internal clock always takes the direct path
  assign sync_path = clock_source_select & ~ext_sync_disable;

  always_ff @(posedge clk_i) begin
    if (rst_i | wr_count | ~sync_path) begin
      pend_ff <= 1'b0;
    end else if (pre_tick & ~phase_q) begin
      pend_ff <= 1'b1;
    end else if (phase_q) begin
      pend_ff <= 1'b0;
    end
  end

  assign inc = sync_path ? ((pre_tick | pend_ff) & phase_q) : pre_tick;

  // wrap from all ones to zero is the overflow event
  assign ovf_ev = inc & ~wr_count & ~ccp_reset_i & (count_ff == sbtc_pkg::COUNT_MAX);

  // count bytes: write first, then trigger clear, then increment
  // deliberately not touched by rst_i so the count survives resets
  always_ff @(posedge clk_i) begin
    if (wr_count) begin
      if (wr_low) begin
        count_ff[7:0] <= wb_dat_i[7:0];
      end
      if (wr_high) begin
        count_ff[15:8] <= wb_dat_i[7:0];
      end
    end else if (ccp_reset_i) begin
      count_ff <= 16'h0000;
    end else if (inc) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  assign count_o = count_ff;

  // sticky overflow flag, write one to clear; a new overflow beats the clear
  assign nxt_flag = (overflow_flag_ff & ~(wr_flag & wb_dat_i[sbtc_pkg::OVF_BIT])) | ovf_ev;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_flag_ff <= sbtc_pkg::FLAG_RESET;
    end else begin
      overflow_flag_ff <= nxt_flag;
    end
  end

  // level interrupt gated by the enable bit
  assign irq_o = overflow_flag_ff & overflow_irq_enable_ff;

endmodule : sbtc_timer

// ### bench/sbtc_assertions.sv
// sbtc_checker: concurrent checks on the ports of sbtc_timer.
// assumes it is bound into each sbtc_timer; one clock domain, reset rst_i.
`timescale 1ns/1ps
module sbtc_checker #(
  parameter int ADDR_W = 8
) (
  // clock, reset and bus
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  // count, pins and interrupt
  input wire logic              ccp_reset_i,
  input wire logic [15:0]       count_o,
  input wire logic [1:0]        port_direction_bits_i,
  input wire logic              osc_in_pin_oe_o,
  input wire logic              osc_out_pin_oe_o,
  input wire logic              osc_amp_en_o,
  input wire logic              irq_o
);
  logic wr_cnt;
  logic wr_lo;
  // a count write lands at the edge that samples ack
  assign wr_lo  = wb_ack_o & wb_we_i & wb_sel_i[0]
                & (wb_adr_i == ADDR_W'(sbtc_pkg::ADDR_COUNT_LOW));
  assign wr_cnt = wr_lo | (wb_ack_o & wb_we_i & wb_sel_i[0]
                & (wb_adr_i == ADDR_W'(sbtc_pkg::ADDR_COUNT_HIGH)));

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // no write and no clear pending: only a tick may move the count
  sequence s_quiet;
    !wr_cnt && !ccp_reset_i;
  endsequence
  sequence s_at_max;
    count_o == sbtc_pkg::COUNT_MAX ##0 s_quiet;
  endsequence

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_step_one: assert property (s_quiet ##1 $changed(count_o) |->
    count_o == $past(count_o) + 16'h1) else $error("count moved by other than one");
  a_wrap_zero: assert property (s_at_max ##1 count_o != sbtc_pkg::COUNT_MAX |->
    count_o == 16'h0) else $error("count did not wrap to zero");
  a_ccp_clear: assert property (ccp_reset_i && !wr_cnt |=> count_o == 16'h0)
    else $error("trigger did not clear count");
  a_write_wins: assert property (wr_lo && ccp_reset_i |=>
    count_o[7:0] == $past(wb_dat_i[7:0])) else $error("trigger beat the write");
  a_osc_inputs: assert property (osc_amp_en_o |-> !osc_in_pin_oe_o && !osc_out_pin_oe_o)
    else $error("pin driven while oscillator on");
  a_pin_dir: assert property (!osc_amp_en_o |->
    osc_out_pin_oe_o == !port_direction_bits_i[0] &&
    osc_in_pin_oe_o == !port_direction_bits_i[1]) else $error("pin enable ignores direction");
  a_irq_cause: assert property ($rose(irq_o) |->
    $past(count_o) == sbtc_pkg::COUNT_MAX || $past(wb_ack_o && wb_we_i))
    else $error("interrupt without overflow or write");
  a_ctl_upper: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i &&
    wb_adr_i == ADDR_W'(sbtc_pkg::ADDR_CONTROL) |=> wb_dat_o[31:6] == 26'h0)
    else $error("unimplemented control bits read nonzero");
endmodule : sbtc_checker

bind sbtc_timer sbtc_checker #(.ADDR_W(ADDR_W)) i_sbtc_checker (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .ccp_reset_i, .count_o, .port_direction_bits_i,
  .osc_in_pin_oe_o, .osc_out_pin_oe_o, .osc_amp_en_o, .irq_o);

// ### bench/sbtc_pulse_src.sv
// sbtc_pulse_src: pulse sources for the external clock pin and the crystal pin.
// assumes the timer samples both pins with its own clock; pins idle low.
`timescale 1ns/1ps
module sbtc_pulse_src (
  // pin drive
  output logic ext_o,
  output logic xtal_o
);
  initial begin
    ext_o  = 1'b0;
    xtal_o = 1'b0;
  end
  // 64 ns period, halves well above three clocks; stands low between bursts
  task automatic burst(input logic sel, input int n);
    repeat (n) begin
      if (sel) xtal_o = 1'b1;
      else ext_o = 1'b1;
      #32;
      xtal_o = 1'b0;
      ext_o  = 1'b0;
      #32;
    end
  endtask : burst
endmodule : sbtc_pulse_src

// ### bench/tb.sv
// tb: self-checking bench for sbtc_timer driven over classic wishbone.
// assumes a 200 MHz clock and pulse sources on both oscillator pins.
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] LO = sbtc_pkg::ADDR_COUNT_LOW;
  localparam logic [7:0] HI = sbtc_pkg::ADDR_COUNT_HIGH;
  localparam logic [7:0] FL = sbtc_pkg::ADDR_FLAG;
  localparam logic [7:0] EN = sbtc_pkg::ADDR_ENABLE;
  localparam logic [7:0] CT = sbtc_pkg::ADDR_CONTROL;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic        capture_compare_unit = 1'b0;
  logic        ccp_with = 1'b0;
  logic [1:0]  dir = 2'h3;
  logic [31:0] rd;
  logic [31:0] dat_o;
  logic [15:0] cnt;
  logic        ack, irq, amp, in_o, in_oe, out_o, out_oe, xtal, ext;
  int          err_count = 0;
  int          cmp_count = 0;
  // pin level: design drive when enabled, else the source
  wire         in_w  = in_oe ? in_o : xtal;
  wire         out_w = out_oe ? out_o : ext;

  sbtc_timer #(.ADDR_W(8)) i_sbtc_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .ccp_reset_i(capture_compare_unit), .count_o(cnt),
    .port_direction_bits_i(dir), .port_out_i(2'h1), .osc_in_pin_i(in_w),
    .osc_in_pin_o(in_o), .osc_in_pin_oe_o(in_oe), .osc_out_pin_i(out_w),
    .osc_out_pin_o(out_o), .osc_out_pin_oe_o(out_oe), .osc_amp_en_o(amp), .irq_o(irq));
  sbtc_pulse_src i_sbtc_pulse_src (.ext_o(ext), .xtal_o(xtal));

  // clock
  always #2.5 clk_i = ~clk_i;

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // one classic cycle; optional trigger pulse lands on the write edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    // ack and read data are sampled at the rising edge, before that edge updates them
    do begin
      @(posedge clk_i);
      if (n == 0 && ccp_with) capture_compare_unit <= 1'b1;
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      err_count++;
      final_report();
    end
    rd = dat_o;
    cyc <= 1'b0;
    capture_compare_unit <= 1'b0;
  endtask : wb

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask : rdchk

  task automatic cnt_is(input string nm, input logic [15:0] e);
    repeat (2) @(negedge clk_i);
    check(nm, {16'h0, cnt}, {16'h0, e});
    $display("test %s done", nm);
  endtask : cnt_is

  // main sequence
  initial begin
    int n;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk("ctl reset", CT, 32'h0);
    rdchk("flag reset", FL, 32'h0);
    rdchk("enable reset", EN, 32'h0);
    rdchk("unmapped", 8'h14, 32'h0);
    @(posedge clk_i);
    capture_compare_unit <= 1'b1;
    @(posedge clk_i);
    capture_compare_unit <= 1'b0;
    cnt_is("trigger clear", 16'h0);
    @(posedge clk_i);
    dir <= 2'h0;
    wb(1'b1, CT, 32'hFF);
    rdchk("ctl bits", CT, 32'h3F);
    check("osc on", {amp, in_oe, out_oe, in_o, out_o}, 5'h11);
    wb(1'b1, CT, 32'h0);
    @(posedge clk_i);
    check("osc off", {amp, in_oe, out_oe, in_o, out_o}, 5'h0D);
    dir <= 2'h3;
    wb(1'b1, HI, 32'h12);
    wb(1'b1, LO, 32'h34);
    rdchk("high rw", HI, 32'h12);
    rdchk("low rw", LO, 32'h34);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    cnt_is("reset keeps count", 16'h1234);
    wb(1'b1, EN, 32'h1);
    wb(1'b1, HI, 32'hFF);
    wb(1'b1, LO, 32'hFE);
    wb(1'b1, CT, 32'h05);
    n = 0;
    while (cnt !== 16'h0 && n < 60) begin
      @(negedge clk_i);
      n++;
    end
    // a wrap that never comes is a failure, not a silent skip
    if (cnt !== 16'h0) begin
      err_count++;
      final_report();
    end
    wb(1'b1, CT, 32'h0);
    check("irq set", irq, 1'b1);
    rdchk("flag set", FL, 32'h1);
    wb(1'b1, EN, 32'h0);
    @(negedge clk_i);
    check("irq masked", irq, 1'b0);
    wb(1'b1, EN, 32'h1);
    wb(1'b1, FL, 32'h1);
    @(negedge clk_i);
    check("irq cleared", irq, 1'b0);
    wb(1'b1, LO, 32'h0);
    wb(1'b1, HI, 32'h0);
    // sync bit left clear here: in timer mode it must not change the rate
    wb(1'b1, CT, 32'h01);
    repeat (400) @(posedge clk_i);
    wb(1'b1, CT, 32'h0);
    repeat (2) @(negedge clk_i);
    check("timer rate", cnt >= 16'h63 && cnt <= 16'h66, 1'b1);
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, LO, 32'h0);
      wb(1'b1, CT, {26'h0, i[1:0], 1'b0, i[2], 2'h3});
      i_sbtc_pulse_src.burst(1'b0, 8);
      repeat (8) @(posedge clk_i);
      wb(1'b1, CT, 32'h0);
      cnt_is("prescale", 16'h8 >> i[1:0]);
    end
    wb(1'b1, CT, 32'h33);
    i_sbtc_pulse_src.burst(1'b0, 4);
    wb(1'b1, LO, 32'h0);
    i_sbtc_pulse_src.burst(1'b0, 4);
    repeat (8) @(posedge clk_i);
    wb(1'b1, CT, 32'h0);
    cnt_is("prescale clear", 16'h0);
    wb(1'b1, CT, 32'h0B);
    i_sbtc_pulse_src.burst(1'b1, 4);
    repeat (8) @(posedge clk_i);
    wb(1'b1, CT, 32'h0);
    cnt_is("crystal pin", 16'h4);
    ccp_with = 1'b1;
    wb(1'b1, LO, 32'h55);
    ccp_with = 1'b0;
    cnt_is("write beats trigger", 16'h55);
    final_report();
  end

  // overall limit on the run
  initial begin
    repeat (100000) @(posedge clk_i);
    err_count++;
    final_report();
  end
endmodule : tb
